// >>> pkg/sei_pkg.sv
// Constants and types shared by the serial EEPROM pin front end.
package sei_pkg;
  // Register offsets on the AHB-Lite register bus.
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_WCYC = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  // Values after reset, and the power-up value of the non-volatile bits.
  localparam logic [15:0] WCYC_RST = 16'h0400;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [2:0] NV_INIT = 3'h0;
  // Status byte, status word and control register field positions.
  localparam int SR_BUSY = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 3;
  localparam int SR_LOCK = 7;
  localparam int ST_SEL = 8;
  localparam int ST_PAUSE = 9;
  localparam int ST_IDLOCK = 10;
  localparam int ST_STBY = 11;
  localparam int CTRL_INHIBIT = 0;
  // Instruction codes: upper nibble zero except the ID page codes 8'h83 and 8'h82, low three bits select the command.
  localparam logic [3:0] OP_HI = 4'h0;
  localparam logic [2:0] OP_WREN = 3'h6;
  localparam logic [2:0] OP_WRDI = 3'h4;
  localparam logic [2:0] OP_RDSR = 3'h5;
  localparam logic [2:0] OP_WRSR = 3'h1;
  localparam logic [2:0] OP_READ = 3'h3;
  localparam logic [2:0] OP_WRITE = 3'h2;
  localparam int OP_A8 = 3;
  localparam logic [7:0] IDOP_RD = 8'h83;
  localparam logic [7:0] IDOP_WR = 8'h82;
  localparam int ID_LOCK_SEL = 7;
  localparam int ID_BYTES = 16;
  // Pin positions in the synchronised pin vector.
  localparam int PIN_SCLK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_MOSI = 2;
  localparam int PIN_HOLD = 3;
  localparam int PIN_WP = 4;
  localparam int PIN_W = 5;

  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_RDSR, ST_SR, ST_END, ST_WAIT
  } sei_state_t;

  typedef enum logic [1:0] {TG_MEM, TG_ID, TG_LOCK} sei_tgt_t;
endpackage

// >>> pkg/sei_buf_if.sv
// Valid and ready hand-off between the read fetcher and the read buffer.
`timescale 1ns/1ps
interface sei_buf_if #(parameter int W = 8);
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic wvalid;
  logic wready;
  logic rvalid;
  logic rready;
  logic flush;
  modport owner (output wdata, wvalid, rready, flush,
                 input wready, rvalid, rdata);
  modport store (input wdata, wvalid, rready, flush,
                 output wready, rvalid, rdata);
endinterface

// >>> hdl/sei_sync.sv
// Two-stage synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
module sei_sync #(parameter int W = 1) (
  // Clocking.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else if (ce) begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// >>> hdl/sei_buf.sv
// Small read-data buffer with valid and ready on both sides.
`timescale 1ns/1ps
module sei_buf #(parameter int DEPTH = 2) (
  // Clocking.
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Buffer port.
  sei_buf_if.store bus
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [7:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == LAST) ? '0 : p + 1'b1;
  endfunction

  assign bus.wready = (count_r != FULL);
  assign bus.rvalid = (count_r != '0);
  assign bus.rdata = mem_r[rd_ptr_r];
  assign push = bus.wvalid && bus.wready;
  assign pop = bus.rready && bus.rvalid;

  always_ff @(posedge clk) begin
    if (ce && push && !bus.flush) begin
      mem_r[wr_ptr_r] <= bus.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || (ce && bus.flush)) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_r <= bump(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= bump(rd_ptr_r);
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// >>> hdl/sei_top.sv
// Serial EEPROM pin front end with memory array and register bus.
//
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module sei_top #(
  parameter int MEM_DEPTH = 512,
  parameter bit HAS_ID = 1'b1,
  parameter int BUF_DEPTH = 2
) (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Serial pins.
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  output logic standby,
  // AHB-Lite register slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);
  localparam int AW = $clog2(MEM_DEPTH);

  logic [sei_pkg::PIN_W-1:0] pin_s;
  logic sclk_s, cs_s, mosi_s, hold_s, wp_s;
  logic sclk_d_r, cs_d_r, armed_r, paused_r;
  logic cs_fall, cs_rise, selected, en_clk, sclk_rise, sclk_fall;
  sei_pkg::sei_state_t state_r;
  sei_pkg::sei_tgt_t tgt_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_in_r, cmd_r, sr_data_r, rx_byte;
  logic wr_op_r, a8_r, any_wr_r, byte_done;
  logic [AW-1:0] addr_r, addr_new, fptr_r;
  logic [7:0] mem_r [MEM_DEPTH];
  logic [7:0] id_r [sei_pkg::ID_BYTES];
  logic wel_r, id_lock_r, inhibit_r;
  logic [2:0] nv_r = sei_pkg::NV_INIT;
  logic [15:0] busy_cnt_r, wcyc_r;
  logic busy, wr_ok, mem_we, lock_ok, lock_sel, fetch_start;
  logic do_wren, do_wrdi, do_wrsr, do_wcyc, do_lock;
  logic miso_r, miso_oe_n_r, standby_r, tx_on_r, fetch_on_r;
  logic [7:0] out_sh_r, tx_byte, status_byte;
  logic [2:0] out_cnt_r;
  logic tx_mode, load_out;
  logic ahb_go, wr_pend_r, hreadyout_r, hresp_r;
  logic [7:0] wr_ofs_r;
  logic [31:0] hrdata_r, rd_word;

  sei_buf_if #(.W(8)) buf_if ();

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] a);
    return a + 1'b1;
  endfunction

  function automatic logic prot(input logic [AW-1:0] a,
                                input logic [1:0] bp);
    case (bp)
      2'h0: prot = 1'b0;
      2'h1: prot = a[AW-1] & a[AW-2];
      2'h2: prot = a[AW-1];
      default: prot = 1'b1;
    endcase
  endfunction

  sei_sync #(.W(sei_pkg::PIN_W)) u_sync (
    .clk(ref_clk),
    .rst(sys_rst),
    .ce(ce),
    .d({wp_n, hold_n, spi_mosi, spi_cs_n, spi_sclk}),
    .q(pin_s)
  );

  sei_buf #(.DEPTH(BUF_DEPTH)) u_buf (
    .clk(ref_clk),
    .rst(sys_rst),
    .ce(ce),
    .bus(buf_if.store)
  );

  assign sclk_s = pin_s[sei_pkg::PIN_SCLK];
  assign cs_s = pin_s[sei_pkg::PIN_CS];
  assign mosi_s = pin_s[sei_pkg::PIN_MOSI];
  assign hold_s = pin_s[sei_pkg::PIN_HOLD];
  assign wp_s = pin_s[sei_pkg::PIN_WP];

  // The edge memories reset low so a select held low through reset is
  // not mistaken for a fresh falling edge.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b0;
    end else if (ce) begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_s;
    end
  end

  assign cs_fall = !cs_s && cs_d_r;
  assign cs_rise = cs_s && !cs_d_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      armed_r <= 1'b0;
    end else if (ce && cs_fall) begin
      armed_r <= 1'b1;
    end
  end

  assign selected = armed_r && !cs_s;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      paused_r <= 1'b0;
    end else if (ce) begin
      if (!selected) begin
        paused_r <= 1'b0;
      end else if (!sclk_s) begin
        paused_r <= !hold_s;
      end
    end
  end

  assign en_clk = selected && !paused_r;
  assign sclk_rise = en_clk && sclk_s && !sclk_d_r;
  assign sclk_fall = en_clk && !sclk_s && sclk_d_r;
  assign byte_done = sclk_rise && (bit_cnt_r == 3'h7);
  assign rx_byte = {shift_in_r[6:0], mosi_s};
  assign busy = (busy_cnt_r != 16'h0);
  assign addr_new = (tgt_r == sei_pkg::TG_ID) ? AW'(rx_byte[3:0]) :
                    AW'({a8_r, rx_byte});
  assign lock_sel = (tgt_r == sei_pkg::TG_ID) &&
                    rx_byte[sei_pkg::ID_LOCK_SEL];
  assign fetch_start = byte_done && (state_r == sei_pkg::ST_ADDR) &&
                       !wr_op_r && !lock_sel;

  always_ff @(posedge ref_clk) begin
    if (sys_rst || (ce && !selected)) begin
      state_r <= sei_pkg::ST_CMD;
      bit_cnt_r <= 3'h0;
      any_wr_r <= 1'b0;
      tgt_r <= sei_pkg::TG_MEM;
      wr_op_r <= 1'b0;
      a8_r <= 1'b0;
    end else if (ce && sclk_rise) begin
      shift_in_r <= rx_byte;
      bit_cnt_r <= bit_cnt_r + 1'b1;
      case (state_r)
        sei_pkg::ST_CMD: begin
          if (byte_done) begin
            cmd_r <= rx_byte;
            wr_op_r <= !rx_byte[0];
            a8_r <= rx_byte[sei_pkg::OP_A8];
            state_r <= sei_pkg::ST_WAIT;
            if (rx_byte[7:4] == sei_pkg::OP_HI) begin
              case (rx_byte[2:0])
                sei_pkg::OP_WREN, sei_pkg::OP_WRDI: begin
                  state_r <= sei_pkg::ST_END;
                end
                sei_pkg::OP_RDSR: state_r <= sei_pkg::ST_RDSR;
                sei_pkg::OP_WRSR: begin
                  state_r <= busy ? sei_pkg::ST_WAIT : sei_pkg::ST_SR;
                end
                sei_pkg::OP_READ, sei_pkg::OP_WRITE: begin
                  state_r <= busy ? sei_pkg::ST_WAIT : sei_pkg::ST_ADDR;
                end
                default: state_r <= sei_pkg::ST_WAIT;
              endcase
            end else if (HAS_ID && !busy &&
                         (rx_byte == sei_pkg::IDOP_RD ||
                          rx_byte == sei_pkg::IDOP_WR)) begin
              state_r <= sei_pkg::ST_ADDR;
              tgt_r <= sei_pkg::TG_ID;
              a8_r <= 1'b0;
            end
          end
        end
        sei_pkg::ST_ADDR: begin
          if (byte_done) begin
            addr_r <= addr_new;
            if (lock_sel) begin
              tgt_r <= sei_pkg::TG_LOCK;
            end
            state_r <= wr_op_r ? sei_pkg::ST_WDATA : sei_pkg::ST_RDATA;
          end
        end
        sei_pkg::ST_WDATA: begin
          if (byte_done) begin
            addr_r <= inc(addr_r);
            any_wr_r <= any_wr_r || mem_we || lock_ok;
          end
        end
        sei_pkg::ST_SR: begin
          if (byte_done) begin
            sr_data_r <= rx_byte;
            state_r <= sei_pkg::ST_END;
          end
        end
        sei_pkg::ST_END: state_r <= sei_pkg::ST_WAIT;
        default: state_r <= state_r;
      endcase
    end
  end

  // Array bytes are committed as each byte completes, which saves a page
  // buffer; the busy time still starts only on a clean deselect.
  assign wr_ok = wel_r && wp_s && !inhibit_r;
  assign mem_we = byte_done && (state_r == sei_pkg::ST_WDATA) && wr_ok &&
                  ((tgt_r == sei_pkg::TG_MEM && !prot(addr_r, nv_r[1:0])) ||
                   (tgt_r == sei_pkg::TG_ID && !id_lock_r));
  assign lock_ok = byte_done && (state_r == sei_pkg::ST_WDATA) && wr_ok &&
                   (tgt_r == sei_pkg::TG_LOCK) && !id_lock_r;
  assign do_wren = cs_rise && armed_r && (state_r == sei_pkg::ST_END) &&
                   (cmd_r[2:0] == sei_pkg::OP_WREN);
  assign do_wrdi = cs_rise && armed_r && (state_r == sei_pkg::ST_END) &&
                   (cmd_r[2:0] == sei_pkg::OP_WRDI);
  assign do_wrsr = cs_rise && armed_r && (state_r == sei_pkg::ST_END) &&
                   (cmd_r[2:0] == sei_pkg::OP_WRSR) && wr_ok;
  assign do_lock = cs_rise && armed_r && (state_r == sei_pkg::ST_WDATA) &&
                   (tgt_r == sei_pkg::TG_LOCK) && any_wr_r &&
                   (bit_cnt_r == 3'h0) && wr_ok;
  assign do_wcyc = do_wrsr || do_lock ||
                   (cs_rise && armed_r && (state_r == sei_pkg::ST_WDATA) &&
                    any_wr_r && (bit_cnt_r == 3'h0));

  always_ff @(posedge ref_clk) begin
    if (ce && mem_we && tgt_r == sei_pkg::TG_MEM) begin
      mem_r[addr_r] <= rx_byte;
    end
    if (ce && mem_we && tgt_r == sei_pkg::TG_ID) begin
      id_r[addr_r[3:0]] <= rx_byte;
    end
  end

  // The status register lock and protect bits stand for non-volatile cells, so
  // reset never touches them; the ID page lock is cleared by reset.
  always_ff @(posedge ref_clk) begin
    if (ce && do_wrsr) begin
      nv_r <= {sr_data_r[sei_pkg::SR_LOCK], sr_data_r[sei_pkg::SR_BP_HI],
               sr_data_r[sei_pkg::SR_BP_LO]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      id_lock_r <= 1'b0;
    end else if (ce && do_lock && HAS_ID) begin
      id_lock_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wel_r <= 1'b0;
      busy_cnt_r <= 16'h0;
    end else if (ce) begin
      if (do_wren) begin
        wel_r <= 1'b1;
      end else if (do_wrdi || do_wcyc) begin
        wel_r <= 1'b0;
      end
      if (do_wcyc) begin
        busy_cnt_r <= wcyc_r;
      end else if (busy) begin
        busy_cnt_r <= busy_cnt_r - 1'b1;
      end
    end
  end

  assign status_byte = {nv_r[2], 3'h0, nv_r[1], nv_r[0], wel_r, busy};
  assign tx_mode = (state_r == sei_pkg::ST_RDATA) ||
                   (state_r == sei_pkg::ST_RDSR);
  assign load_out = sclk_fall && tx_mode && (out_cnt_r == 3'h0);
  assign tx_byte = (state_r == sei_pkg::ST_RDSR) ? status_byte :
                   (tgt_r == sei_pkg::TG_LOCK) ? {7'h0, id_lock_r} :
                   buf_if.rdata;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fetch_on_r <= 1'b0;
      fptr_r <= '0;
    end else if (ce) begin
      if (!selected) begin
        fetch_on_r <= 1'b0;
      end else if (fetch_start) begin
        fetch_on_r <= 1'b1;
        fptr_r <= addr_new;
      end else if (buf_if.wvalid && buf_if.wready) begin
        fptr_r <= inc(fptr_r);
      end
    end
  end

  assign buf_if.wvalid = fetch_on_r && selected;
  assign buf_if.wdata = (tgt_r == sei_pkg::TG_ID) ? id_r[fptr_r[3:0]] :
                        mem_r[fptr_r];
  assign buf_if.flush = fetch_start || !selected;
  assign buf_if.rready = load_out && (state_r == sei_pkg::ST_RDATA) &&
                         (tgt_r != sei_pkg::TG_LOCK);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      miso_r <= 1'b0;
      out_sh_r <= 8'h00;
      out_cnt_r <= 3'h0;
      tx_on_r <= 1'b0;
      miso_oe_n_r <= 1'b1;
    end else if (ce) begin
      miso_oe_n_r <= !(selected && !paused_r && (tx_on_r || load_out));
      if (!selected) begin
        tx_on_r <= 1'b0;
        out_cnt_r <= 3'h0;
      end else if (load_out) begin
        miso_r <= tx_byte[7];
        out_sh_r <= {tx_byte[6:0], 1'b0};
        out_cnt_r <= 3'h7;
        tx_on_r <= 1'b1;
      end else if (sclk_fall && tx_on_r) begin
        miso_r <= out_sh_r[7];
        out_sh_r <= {out_sh_r[6:0], 1'b0};
        out_cnt_r <= out_cnt_r - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      standby_r <= 1'b1;
    end else if (ce) begin
      standby_r <= !selected && !busy;
    end
  end

  assign ahb_go = hsel && htrans[1] && hready;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr[7:0] == sei_pkg::OFS_STAT) begin
      rd_word[7:0] = status_byte;
      rd_word[sei_pkg::ST_SEL] = selected;
      rd_word[sei_pkg::ST_PAUSE] = paused_r;
      rd_word[sei_pkg::ST_IDLOCK] = id_lock_r;
      rd_word[sei_pkg::ST_STBY] = standby_r;
    end else if (haddr[7:0] == sei_pkg::OFS_WCYC) begin
      rd_word[15:0] = wcyc_r;
    end else if (haddr[7:0] == sei_pkg::OFS_CTRL) begin
      rd_word[sei_pkg::CTRL_INHIBIT] = inhibit_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      wcyc_r <= sei_pkg::WCYC_RST;
      inhibit_r <= sei_pkg::CTRL_RST;
    end else if (ce) begin
      wr_pend_r <= ahb_go && hwrite && (haddr[31:8] == 24'h000000);
      wr_ofs_r <= haddr[7:0];
      if (ahb_go && !hwrite && haddr[31:8] == 24'h000000) begin
        hrdata_r <= rd_word;
      end else if (ahb_go) begin
        hrdata_r <= 32'h0000_0000;
      end
      if (wr_pend_r && wr_ofs_r == sei_pkg::OFS_WCYC) begin
        wcyc_r <= hwdata[15:0];
      end else if (wr_pend_r && wr_ofs_r == sei_pkg::OFS_CTRL) begin
        inhibit_r <= hwdata[sei_pkg::CTRL_INHIBIT];
      end
    end
  end

  assign spi_miso = miso_r;
  assign spi_miso_oe_n = miso_oe_n_r;
  assign standby = standby_r;
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !ce);

  property p_miso_fall;
    !$past(sclk_fall) |-> $stable(miso_r);
  endproperty
  a_miso_fall: assert property (p_miso_fall)
    else $error("serial output changed without a clock fall");

  property p_rise_capture;
    sclk_rise |=> shift_in_r[0] == $past(mosi_s);
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("input bit not captured at clock rise");

  property p_desel_hiz;
    cs_s |=> miso_oe_n_r;
  endproperty
  a_desel_hiz: assert property (p_desel_hiz)
    else $error("output driven while deselected");

  property p_standby;
    !selected && !busy |=> standby_r;
  endproperty
  a_standby: assert property (p_standby)
    else $error("not in standby while idle and deselected");

  property p_arm;
    $rose(armed_r) |-> $past(cs_fall);
  endproperty
  a_arm: assert property (p_arm)
    else $error("selected without a select fall");

  property p_pause;
    paused_r && selected |=> miso_oe_n_r && $stable(bit_cnt_r);
  endproperty
  a_pause: assert property (p_pause)
    else $error("pause did not freeze the link");

  property p_wp;
    !wp_s |-> !mem_we && !do_wrsr && !do_lock;
  endproperty
  a_wp: assert property (p_wp)
    else $error("write accepted with write protect low");

  property p_por;
    $fell(sys_rst) |-> !wel_r && !busy && !armed_r && standby_r;
  endproperty
  a_por: assert property (p_por)
    else $error("wrong state after reset release");

  property p_msb;
    load_out |=> miso_r == $past(tx_byte[7]);
  endproperty
  a_msb: assert property (p_msb)
    else $error("byte not sent most significant bit first");

  property p_discard;
    cs_rise |=> state_r == sei_pkg::ST_CMD && bit_cnt_r == 3'h0;
  endproperty
  a_discard: assert property (p_discard)
    else $error("partial command kept across deselect");

  property p_fetch_ready;
    buf_if.rready |-> buf_if.rvalid;
  endproperty
  a_fetch_ready: assert property (p_fetch_ready)
    else $error("read buffer empty when a byte was due");

  c_read: cover property (buf_if.rready);
  c_write: cover property (do_wcyc);
  c_pause: cover property ($rose(paused_r));
  c_rdsr: cover property (load_out && state_r == sei_pkg::ST_RDSR);
endmodule

// >>> bench/sei_master.sv
// SPI bus master model that drives the serial pins of the EEPROM front end.
`timescale 1ns/1ps
module sei_master (
  // Serial pins.
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi,
  output logic hold_n,
  input wire logic spi_miso,
  input wire logic spi_miso_oe_n
);
  logic last;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    hold_n = 1'b1;
    last = 1'b0;
  end
  task automatic sel();
    spi_cs_n = 1'b1;
    #202 spi_cs_n = 1'b0;
    #100;
  endtask
  // The data line is released with the inverse of its last bit on purpose.
  task automatic desel();
    #100 spi_cs_n = 1'b1;
    spi_mosi = ~last;
    #200;
  endtask
  task automatic xb(input logic [7:0] d, input int n, output logic [7:0] q);
    for (int i = 7; i >= 8 - n; i--) begin
      spi_mosi = d[i];
      last = d[i];
      #62 spi_sclk = 1'b1;
      q[i] = spi_miso_oe_n ? ~spi_miso : spi_miso;
      #63 spi_sclk = 1'b0;
    end
  endtask
  // The clock keeps toggling during the pause so that ignoring it is tested.
  task automatic pause();
    #80 hold_n = 1'b0;
    repeat (3) begin
      #62 spi_sclk = 1'b1;
      #63 spi_sclk = 1'b0;
    end
    #40 hold_n = 1'b1;
    #100;
  endtask
endmodule

// >>> bench/sei_top_tb_top.sv
// Self-checking bench for the serial EEPROM pin front end.
`timescale 1ns/1ps
module sei_top_tb_top;
  logic ref_clk, sys_rst, ce, wp_n, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, seed;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic sclk, cs_n, mosi, hold_n, miso, oe_n, standby;
  logic [7:0] q;
  logic inh;
  int miscompares, n_compared, a;
  int mem[int];
  sei_top dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce(ce),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .hold_n(hold_n),
    .wp_n(wp_n), .spi_miso(miso), .spi_miso_oe_n(oe_n), .standby(standby),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp));
  sei_master m (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .hold_n(hold_n), .spi_miso(miso), .spi_miso_oe_n(oe_n));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (e !== g) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] ad,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    chk("hresp", 0, hresp);
    if (n >= 100) begin
      miscompares++;
      results();
    end
  endtask
  task automatic wren();
    m.sel();
    chk("standby_sel", 0, standby);
    m.xb({sei_pkg::OP_HI, 1'b0, sei_pkg::OP_WREN}, 8, q);
    m.desel();
  endtask
  task automatic wr(input int ad, input logic [7:0] x, y);
    wren();
    m.sel();
    m.xb({sei_pkg::OP_HI, ad[8], sei_pkg::OP_WRITE}, 8, q);
    m.xb(ad[7:0], 8, q);
    m.xb(x, 8, q);
    m.xb(y, 8, q);
    m.desel();
    if (wp_n && !inh) begin
      mem[ad] = x;
      mem[(ad + 1) % 512] = y;
    end
    ahb(1'b0, sei_pkg::OFS_STAT, 32'h0);
    chk("busy", wp_n && !inh, rd[sei_pkg::SR_BUSY]);
    for (int n = 0; n < 100 && rd[0] !== 1'b0; n++) begin
      ahb(1'b0, sei_pkg::OFS_STAT, 32'h0);
    end
    chk("busy_end", 0, rd[0]);
    if (rd[0] !== 1'b0) results();
    chk("standby_idle", 1, standby);
  endtask
  task automatic rdm(input int ad);
    m.sel();
    m.xb({sei_pkg::OP_HI, ad[8], sei_pkg::OP_READ}, 8, q);
    m.xb(ad[7:0], 8, q);
    m.xb(8'h00, 8, q);
    chk("rd0", mem[ad], q);
    fork
      m.pause();
      begin
        #200;
        chk("oe_pause", 1, oe_n);
      end
    join
    m.xb(8'h00, 8, q);
    chk("rd1", mem[(ad + 1) % 512], q);
    m.desel();
    chk("oe_desel", 1, oe_n);
  endtask
  initial begin
    seed = 32'h7E5A;
    sys_rst = 1'b1;
    ce = 1'b1;
    wp_n = 1'b1;
    inh = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (12) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk("oe_rst", 1, oe_n);
    chk("standby_rst", 1, standby);
    ahb(1'b0, sei_pkg::OFS_STAT, 32'h0);
    chk("stat_rst", 32'h1 << sei_pkg::ST_STBY, rd);
    ahb(1'b0, sei_pkg::OFS_WCYC, 32'h0);
    chk("wcyc_rst", sei_pkg::WCYC_RST, rd);
    ahb(1'b1, sei_pkg::OFS_WCYC, 32'hC8);
    ahb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 0, rd);
    ahb(1'b0, sei_pkg::OFS_WCYC, 32'h0);
    chk("wcyc", 32'hC8, rd);
    m.sel();
    m.xb({sei_pkg::OP_HI, 1'b0, sei_pkg::OP_WREN}, 6, q);
    m.desel();
    ahb(1'b0, sei_pkg::OFS_STAT, 32'h0);
    chk("wel_part", 0, rd[sei_pkg::SR_WEL]);
    wren();
    ahb(1'b0, sei_pkg::OFS_STAT, 32'h0);
    chk("wel", 1, rd[sei_pkg::SR_WEL]);
    m.sel();
    m.xb({sei_pkg::OP_HI, 1'b0, sei_pkg::OP_RDSR}, 8, q);
    m.xb(8'h00, 8, q);
    m.desel();
    chk("rdsr", 32'h1 << sei_pkg::SR_WEL, q);
    m.sel();
    m.xb({sei_pkg::OP_HI, 1'b0, sei_pkg::OP_WRDI}, 8, q);
    m.desel();
    ahb(1'b0, sei_pkg::OFS_STAT, 32'h0);
    chk("wrdi", 0, rd[sei_pkg::SR_WEL]);
    for (int i = 0; i < 2; i++) begin
      a = int'(rnd() % 32'h200);
      wr(a, 8'(rnd()), 8'(rnd()));
      rdm(a);
    end
    ahb(1'b1, sei_pkg::OFS_CTRL, 32'h1);
    ahb(1'b0, sei_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    inh = 1'b1;
    wr(a, 8'(~mem[a]), 8'hA5);
    rdm(a);
    ahb(1'b1, sei_pkg::OFS_CTRL, 32'h0);
    inh = 1'b0;
    @(posedge ref_clk);
    wp_n <= 1'b0;
    wr(a, 8'(~mem[a]), 8'h5A);
    rdm(a);
    results();
  end
endmodule
